// ### core/pcs_pwm_front.sv
// Four-channel waveform generator front end with Wishbone registers
// Functional notes
// - Four 8-bit channels, two 16-bit, or one 16-bit plus two 8-bit.
// - Each channel has counter, period, duty, left or center alignment.
// - While enabled, period and duty writes wait for rollover or disable.
// - While disabled, period and duty writes reach active latch at once.
// - Counter write clears counter and latches buffered period and duty.
// - Enabled channel owns its pin unless it is a joined low channel; unused pins stay general I/O.
// - Upper join: ch2 high byte, ch3 low, out on pin 2, ch3 clock.
// - Lower join: ch0 high byte, ch1 low, out on pin 0, ch1 clock.
// - Clock A is module clock divided by two to the code power.
// - Clock B uses its own three-bit code, same power-of-two encoding.
// - Ch3 and ch2 select clock B or scaled upper clock, bits 7 and 6.
// - Ch1 and ch0 select clock A or scaled lower clock, bits 5 and 4.
// - Clock select change may give one truncated or stretched pulse.
// - Left mode: start-high bit 0 starts low, 1 starts high.
// - Enable forces pin to output, except on a joined low channel, without altering the direction bit.
// - Enable gates selected clock; all off stops the prescaler.
// - Channel clock gating changes only on a clock tick edge.
// - Waveform reaches pin one module clock cycle after the counter step.
// - Lower scaled clock is clock A over scale plus one, halved.
// - Upper scaled clock is clock B over scale plus one, halved.
// - Reading a counter does not disturb counting or output.
`timescale 1ns/1ps
`default_nettype none

module pcs_pwm_front (
    input wire logic ref_clk,
    input wire logic rst,
    input wire pcs_pkg::pcs_wb_req_type wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n
);

    // Power-of-two tick mask for a three-bit divider code
    function automatic logic [6:0] pcs_mask(input logic [2:0] code);
        logic [7:0] full;
        full = (8'h01 << code) - 8'h01;
        return full[6:0];
    endfunction

    // One counter step in left or center alignment
    function automatic pcs_pkg::pcs_step_type pcs_step(
        input logic [15:0] cnt, input logic [15:0] per,
        input logic ctr, input logic up);
        pcs_pkg::pcs_step_type s;
        s.roll = 1'b0;
        s.up = up;
        s.cnt = cnt + 16'h0001;
        if (!ctr) begin
            s.up = 1'b1;
            if (cnt >= per) begin
                s.cnt = 16'h0000;
                s.roll = 1'b1;
            end
        end else if (up) begin
            if (cnt >= per) begin
                s.up = 1'b0;
                s.cnt = cnt - 16'h0001;
            end
        end else if (cnt != 16'h0000) begin
            s.cnt = cnt - 16'h0001;
        end else begin
            s.up = 1'b1;
            s.roll = 1'b1;
        end
        return s;
    endfunction

    // Register state
    localparam int NCH_L = pcs_pkg::NCH;
    logic [7:0] clkp_q;
    logic [7:0] pol_q;
    logic [3:0] en_q;
    logic [3:0] ctr_q;
    logic [3:0] pdata_q;
    logic [3:0] pdir_q;
    logic [6:0] presc_q;
    logic [7:0] scal_q [2];
    logic [7:0] scnt_q [2];
    logic [1:0] half_q;
    logic [7:0] cnt_q [NCH_L];
    logic [7:0] per_buf_q [NCH_L];
    logic [7:0] per_act_q [NCH_L];
    logic [7:0] dty_buf_q [NCH_L];
    logic [7:0] dty_act_q [NCH_L];
    logic [3:0] up_q;
    logic [3:0] run_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [3:0] pin_out_q;
    logic [3:0] pin_oe_n_q;

    // Bus decode
    wire req = wb_req.cyc & wb_req.stb;
    wire wr = req & wb_req.we & ~ack_q & wb_req.sel[0];
    wire rd = req & ~wb_req.we & ~ack_q;
    wire [7:0] idx = wb_req.adr[9:2];
    wire [7:0] wdat = wb_req.dat[7:0];
    wire [7:0] rel_full = idx - pcs_pkg::IDX_CLKP;
    wire [4:0] rel = rel_full[4:0];
    wire in_map = (idx >= pcs_pkg::IDX_CLKP) && (idx <= pcs_pkg::IDX_PIN);
    wire [1:0] chsel = idx[1:0];
    wire cnt_grp = (idx[7:2] == pcs_pkg::IDX_CNT0[7:2]);
    wire per_grp = (idx[7:2] == pcs_pkg::IDX_PER0[7:2]);
    wire dty_grp = (idx[7:2] == pcs_pkg::IDX_DTY0[7:2]);

    // Control fields
    wire [1:0] join_pair = {clkp_q[pcs_pkg::UPPER_JOIN_BIT],
                            clkp_q[pcs_pkg::LOWER_JOIN_BIT]};
    wire [2:0] code_a = clkp_q[pcs_pkg::CLKA_LSB +: 3];
    wire [2:0] code_b = clkp_q[pcs_pkg::CLKB_LSB +: 3];
    wire [3:0] scaled_sel = pol_q[pcs_pkg::SCALED_SEL_LSB +: 4];
    wire [3:0] start_high = pol_q[pcs_pkg::START_HIGH_LSB +: 4];
    wire any_en = |en_q;

    // Prescaled clock ticks A and B off the module clock
    wire [1:0] ab_tick;
    assign ab_tick[0] = any_en
        && ((presc_q & pcs_mask(code_a)) == pcs_mask(code_a));
    assign ab_tick[1] = any_en
        && ((presc_q & pcs_mask(code_b)) == pcs_mask(code_b));

    // Scaled clocks: divide by scale plus one, then by two
    wire [1:0] s_tick;
    assign s_tick[0] = ab_tick[0] && scnt_q[0] == 8'h00 && half_q[0];
    assign s_tick[1] = ab_tick[1] && scnt_q[1] == 8'h00 && half_q[1];

    // Per-channel decode and engines
    wire [3:0] tick_src;
    wire [3:0] eff_tick;
    wire [3:0] eff_en;
    wire [3:0] step;
    wire [3:0] roll;
    wire [3:0] up_d;
    wire [7:0] cnt_d [NCH_L];
    wire [3:0] wave;
    wire [3:0] owns;
    wire [3:0] cnt_wr;
    wire [3:0] per_wr;
    wire [3:0] dty_wr;
    wire [3:0] latch;

    genvar gi;
    generate
        for (gi = 0; gi < NCH_L; gi++) begin : g_ch
            // Clock choice: prescaled or scaled of the channel's group
            assign tick_src[gi] = scaled_sel[gi] ? s_tick[gi / 2]
                                                 : ab_tick[gi / 2];
            assign cnt_wr[gi] = wr && cnt_grp && chsel == 2'(gi);
            assign per_wr[gi] = wr && per_grp && chsel == 2'(gi);
            assign dty_wr[gi] = wr && dty_grp && chsel == 2'(gi);
            assign step[gi] = eff_tick[gi] & run_q[gi];
            // Disabled, counter written, or rolled over: load latches
            assign latch[gi] = ~eff_en[gi] | cnt_wr[gi]
                             | (step[gi] & roll[gi]);
        end
        for (gi = 0; gi < 2; gi++) begin : g_pair
            localparam int HI = 2 * gi;
            localparam int LO = 2 * gi + 1;
            wire pcs_pkg::pcs_step_type e_hi;
            wire pcs_pkg::pcs_step_type e_lo;
            wire pcs_pkg::pcs_step_type e_j;
            wire act_hi;
            wire act_lo;
            wire act_j;
            assign e_hi = pcs_step({8'h00, cnt_q[HI]}, {8'h00, per_act_q[HI]},
                                   ctr_q[HI], up_q[HI]);
            assign e_lo = pcs_step({8'h00, cnt_q[LO]}, {8'h00, per_act_q[LO]},
                                   ctr_q[LO], up_q[LO]);
            // Joined pair: high channel is high byte
            assign e_j = pcs_step({cnt_q[HI], cnt_q[LO]},
                                  {per_act_q[HI], per_act_q[LO]},
                                  ctr_q[LO], up_q[LO]);
            assign act_hi = cnt_q[HI] < dty_act_q[HI];
            assign act_lo = cnt_q[LO] < dty_act_q[LO];
            assign act_j = {cnt_q[HI], cnt_q[LO]}
                         < {dty_act_q[HI], dty_act_q[LO]};
            // Joined pair runs on low channel's clock, high channel's enable
            assign eff_tick[HI] = join_pair[gi] ? tick_src[LO]
                                                : tick_src[HI];
            assign eff_tick[LO] = tick_src[LO];
            assign eff_en[HI] = en_q[HI];
            assign eff_en[LO] = join_pair[gi] ? en_q[HI] : en_q[LO];
            assign cnt_d[HI] = join_pair[gi] ? e_j.cnt[15:8] : e_hi.cnt[7:0];
            assign cnt_d[LO] = join_pair[gi] ? e_j.cnt[7:0] : e_lo.cnt[7:0];
            assign roll[HI] = join_pair[gi] ? e_j.roll : e_hi.roll;
            assign roll[LO] = join_pair[gi] ? e_j.roll : e_lo.roll;
            assign up_d[HI] = join_pair[gi] ? e_j.up : e_hi.up;
            assign up_d[LO] = join_pair[gi] ? e_j.up : e_lo.up;
            // Start level while below duty, opposite level after
            assign wave[HI] = (join_pair[gi] ? act_j : act_hi)
                            ? start_high[HI] : ~start_high[HI];
            assign wave[LO] = act_lo ? start_high[LO] : ~start_high[LO];
            // Low channel's pin reverts to general I/O when joined
            assign owns[HI] = en_q[HI];
            assign owns[LO] = en_q[LO] & ~join_pair[gi];
        end
    endgenerate

    // Read data selection; counter reads have no side effect
    wire [7:0] rd_word [24];
    assign rd_word[0] = clkp_q;
    assign rd_word[1] = pol_q;
    assign rd_word[2] = {4'h0, en_q};
    assign rd_word[3] = {1'b0, presc_q};
    assign rd_word[4] = scal_q[0];
    assign rd_word[5] = scnt_q[0];
    assign rd_word[6] = scal_q[1];
    assign rd_word[7] = scnt_q[1];
    generate
        for (gi = 0; gi < NCH_L; gi++) begin : g_rd
            assign rd_word[8 + gi] = cnt_q[gi];
            assign rd_word[12 + gi] = per_buf_q[gi];
            assign rd_word[16 + gi] = dty_buf_q[gi];
        end
    endgenerate
    assign rd_word[20] = {4'h0, ctr_q};
    assign rd_word[21] = {4'h0, pdata_q};
    assign rd_word[22] = {4'h0, pdir_q};
    assign rd_word[23] = {4'h0, pin_in};
    wire [7:0] rd_data = in_map ? rd_word[rel] : 8'h00;

    // Bus answer one cycle after the request; unmapped reads zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            dat_q <= rd ? {24'h00_0000, rd_data} : 32'h0000_0000;
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clkp_q <= pcs_pkg::CLKP_RST;
            pol_q <= pcs_pkg::POL_RST;
            en_q <= pcs_pkg::EN_RST;
            ctr_q <= 4'h0;
            pdata_q <= 4'h0;
            pdir_q <= 4'h0;
        end else if (wr) begin
            if (idx == pcs_pkg::IDX_CLKP) clkp_q <= wdat;
            if (idx == pcs_pkg::IDX_POL) pol_q <= wdat;
            if (idx == pcs_pkg::IDX_EN) en_q <= wdat[3:0];
            if (idx == pcs_pkg::IDX_CENTER) ctr_q <= wdat[3:0];
            if (idx == pcs_pkg::IDX_PDATA) pdata_q <= wdat[3:0];
            if (idx == pcs_pkg::IDX_PDIR) pdir_q <= wdat[3:0];
        end
    end

    // Shared prescaler stops while every channel is off
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presc_q <= pcs_pkg::PRESC_RST;
        end else if (any_en) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    // Scale down-counters reload at zero and on a scale write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int g = 0; g < 2; g++) begin
                scal_q[g] <= pcs_pkg::SCAL_RST;
                scnt_q[g] <= pcs_pkg::SCAL_RST;
            end
            half_q <= 2'h0;
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (wr && idx == (g == 0 ? pcs_pkg::IDX_SCAL0
                                         : pcs_pkg::IDX_SCAL1)) begin
                    scal_q[g] <= wdat;
                    scnt_q[g] <= wdat;
                end else if (ab_tick[g]) begin
                    if (scnt_q[g] == 8'h00) begin
                        scnt_q[g] <= scal_q[g];
                        half_q[g] <= ~half_q[g];
                    end else begin
                        scnt_q[g] <= scnt_q[g] - 8'h01;
                    end
                end
            end
        end
    end

    // Channel counters, buffers and active latches
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NCH_L; i++) begin
                cnt_q[i] <= 8'h00;
                per_buf_q[i] <= pcs_pkg::PER_RST;
                per_act_q[i] <= pcs_pkg::PER_RST;
                dty_buf_q[i] <= pcs_pkg::DTY_RST;
                dty_act_q[i] <= pcs_pkg::DTY_RST;
            end
            up_q <= 4'hF;
            run_q <= 4'h0;
        end else begin
            for (int i = 0; i < NCH_L; i++) begin
                if (per_wr[i]) per_buf_q[i] <= wdat;
                if (dty_wr[i]) dty_buf_q[i] <= wdat;
                if (latch[i]) begin
                    per_act_q[i] <= per_wr[i] ? wdat : per_buf_q[i];
                    dty_act_q[i] <= dty_wr[i] ? wdat : dty_buf_q[i];
                end
                if (cnt_wr[i]) begin
                    cnt_q[i] <= 8'h00;
                    up_q[i] <= 1'b1;
                end else if (step[i]) begin
                    cnt_q[i] <= cnt_d[i];
                    up_q[i] <= up_d[i];
                end
                // Enable takes hold only at a tick of the chosen clock
                if (eff_tick[i]) run_q[i] <= eff_en[i];
            end
        end
    end

    // Pin drive: enabled channel, unless joined low, owns pin regardless of direction bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_out_q <= 4'h0;
            pin_oe_n_q <= 4'hF;
        end else begin
            pin_out_q <= (owns & run_q & wave)
                       | (~(owns & run_q) & pdata_q);
            pin_oe_n_q <= ~(owns | pdir_q);
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign pin_out = pin_out_q;
    assign pin_oe_n = pin_oe_n_q;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_cnt0_write;
        cnt_wr[0] && !per_wr[0];
    endsequence
    sequence s_cnt0_cleared;
        cnt_q[0] == 8'h00 && per_act_q[0] == $past(per_buf_q[0]);
    endsequence

    a_ack_single_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_cnt_write_clear: assert property (
        s_cnt0_write |=> s_cnt0_cleared)
        else $error("counter write did not clear and latch");
    a_buffer_holds_on: assert property (
        (per_wr[0] && eff_en[0] && !step[0] && !cnt_wr[0])
        |=> per_act_q[0] == $past(per_act_q[0]))
        else $error("period reached latch while enabled");
    a_direct_when_off: assert property (
        (per_wr[0] && !eff_en[0]) |=> per_act_q[0] == $past(wdat))
        else $error("period not latched while disabled");
    a_presc_idle_stop: assert property (
        !any_en |=> presc_q == $past(presc_q))
        else $error("prescaler ran with all channels off");
    a_clock_a_rate: assert property (
        (ab_tick[0] && code_a == 3'h3) |-> presc_q[2:0] == 3'h7)
        else $error("clock A tick off its power of two");
    a_gate_at_tick: assert property (
        (run_q[0] != $past(run_q[0])) |-> $past(eff_tick[0]))
        else $error("channel gate changed between ticks");
    a_pin_taken_over: assert property (
        (en_q[2] && !join_pair[1]) |=> !pin_oe_n[2])
        else $error("enabled channel did not drive pin");
    a_joined_pin_free: assert property (
        (join_pair[0] && !pdir_q[1]) [*2] |-> pin_oe_n[1])
        else $error("joined low channel still drives pin");
    a_scale_reload: assert property (
        (wr && idx == pcs_pkg::IDX_SCAL0) |=> scnt_q[0] == $past(wdat))
        else $error("scale write did not load counter");

endmodule // pcs_pwm_front

`default_nettype wire

// ### core/pcs_pkg.sv
// Constants and carrier types of the waveform clock front end
package pcs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CLKP = 8'h40;
    localparam logic [7:0] IDX_POL = 8'h41;
    localparam logic [7:0] IDX_EN = 8'h42;
    localparam logic [7:0] IDX_PRESC = 8'h43;
    localparam logic [7:0] IDX_SCAL0 = 8'h44;
    localparam logic [7:0] IDX_SCNT0 = 8'h45;
    localparam logic [7:0] IDX_SCAL1 = 8'h46;
    localparam logic [7:0] IDX_SCNT1 = 8'h47;
    localparam logic [7:0] IDX_CNT0 = 8'h48;
    localparam logic [7:0] IDX_PER0 = 8'h4C;
    localparam logic [7:0] IDX_DTY0 = 8'h50;
    localparam logic [7:0] IDX_CENTER = 8'h54;
    localparam logic [7:0] IDX_PDATA = 8'h55;
    localparam logic [7:0] IDX_PDIR = 8'h56;
    localparam logic [7:0] IDX_PIN = 8'h57;
    // Field positions in clock_prescale_and_pairing
    localparam int UPPER_JOIN_BIT = 7;
    localparam int LOWER_JOIN_BIT = 6;
    localparam int CLKA_LSB = 3;
    localparam int CLKB_LSB = 0;
    // Field positions in clock_choice_and_polarity
    localparam int SCALED_SEL_LSB = 4;
    localparam int START_HIGH_LSB = 0;
    // Reset values
    localparam logic [7:0] CLKP_RST = 8'h00;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [3:0] EN_RST = 4'h0;
    localparam logic [7:0] PER_RST = 8'hFF;
    localparam logic [7:0] DTY_RST = 8'hFF;
    localparam logic [7:0] SCAL_RST = 8'h00;
    localparam logic [6:0] PRESC_RST = 7'h00;
    localparam int NCH = 4;

    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [9:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pcs_wb_req_type;

    // One counter step: rollover, direction, new count
    typedef struct packed {
        logic roll;
        logic up;
        logic [15:0] cnt;
    } pcs_step_type;
endpackage

// ### sim/pcs_pin_model.sv
// Port pin partner: outside drivers on released pins, wire level back in
`timescale 1ns/1ps
`default_nettype none

module pcs_pin_model (
    input wire logic ref_clk,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    output logic [3:0] pin_in
);
    logic [3:0] ext_q = 4'h5;

    // Outside driver toggles each cycle so a released pin never looks held
    always @(posedge ref_clk) begin
        ext_q <= ~ext_q;
    end

    // Wire level: the module wins where it drives, else the outside driver
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_q & pin_oe_n);
endmodule // pcs_pin_model

`default_nettype wire

// ### sim/pcs_pwm_front_tb.sv
// Self-checking bench for the waveform clock front end
`timescale 1ns/1ps
`default_nettype none

module pcs_pwm_front_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    pcs_pkg::pcs_wb_req_type req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe_n;
    int err_count = 0;
    int comparisons = 0;
    logic [7:0] v;
    logic [7:0] w;
    int hi;
    int ri;
    int pin_t[8] = '{0, 0, 0, 0, 2, 2, 0, 2};
    logic [7:0] clk_t[8] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h01, 8'h03,
        8'h00, 8'h00};
    logic [7:0] pol_t[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h10, 8'h40};
    int rise_t[8] = '{32, 16, 8, 4, 16, 4, 8, 8};

    // Module clock, 20 ns period
    always #10 ref_clk = ~ref_clk;

    pcs_pwm_front i_dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .wb_req(req),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n)
    );

    pcs_pin_model i_pins (
        .ref_clk(ref_clk),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n),
        .pin_in(pin_in)
    );

    task automatic final_report();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    // One classic cycle; held until ack is seen high, released after
    task automatic bus(input logic we, input logic [7:0] idx,
        input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge ref_clk);
        req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hF, {24'h0, wd}};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            $display("[ERR] bus wait expected ack seen none");
            err_count++;
            final_report();
        end
        rd = wb_dat_o[7:0];
        req <= '0;
        // Idle edge so register effects have reached the pins
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk($sformatf("reg %h", idx), {8'h00, e}, {8'h00, x});
    endtask

    // High samples and rising edges of one pin over n cycles
    task automatic meas(input int b, input int n, output int h,
        output int r);
        logic p;
        h = 0;
        r = 0;
        @(negedge ref_clk);
        p = pin_out[b];
        repeat (n) begin
            @(negedge ref_clk);
            if (pin_out[b] === 1'b1) h++;
            if (pin_out[b] === 1'b1 && p === 1'b0) r++;
            p = pin_out[b];
        end
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values and read-only places
        chk("oe_n", 16'h000F, {12'h0, pin_oe_n});
        rd(8'h40, 8'h00);
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
        rd(8'h4C, 8'hFF);
        rd(8'h50, 8'hFF);
        wr(8'h43, 8'h07);
        rd(8'h43, 8'h00);
        wr(8'h60, 8'h5A);
        rd(8'h60, 8'h00);
        wr(8'h40, 8'hA5);
        rd(8'h40, 8'hA5);
        wr(8'h42, 8'hFF);
        rd(8'h42, 8'h0F);
        wr(8'h42, 8'h00);
        $display("test reset and registers done");
        // Port pins as plain outputs while no channel runs
        wr(8'h56, 8'h0F);
        wr(8'h55, 8'h0A);
        chk("pin_out", 16'h000A, {12'h0, pin_out});
        chk("oe_n", 16'h0000, {12'h0, pin_oe_n});
        rd(8'h57, 8'h0A);
        wr(8'h56, 8'h00);
        chk("oe_n", 16'h000F, {12'h0, pin_oe_n});
        $display("test port pins done");
        // Left mode polarity on channel 0, period 3 duty 1
        wr(8'h40, 8'h00);
        wr(8'h41, 8'h00);
        wr(8'h4C, 8'h03);
        wr(8'h50, 8'h01);
        wr(8'h4E, 8'h03);
        wr(8'h52, 8'h01);
        wr(8'h48, 8'h00);
        wr(8'h42, 8'h01);
        chk("oe_n", 16'h000E, {12'h0, pin_oe_n});
        rd(8'h56, 8'h00);
        repeat (10) @(posedge ref_clk);
        meas(0, 40, hi, ri);
        chk("high low start", 16'd30, hi[15:0]);
        wr(8'h41, 8'h01);
        repeat (10) @(posedge ref_clk);
        meas(0, 40, hi, ri);
        chk("high high start", 16'd10, hi[15:0]);
        wr(8'h42, 8'h00);
        chk("oe_n", 16'h000F, {12'h0, pin_oe_n});
        // Center mode on channel 0: up to 3, down to 0, six ticks a period
        wr(8'h41, 8'h00);
        wr(8'h54, 8'h01);
        wr(8'h48, 8'h00);
        wr(8'h42, 8'h01);
        repeat (10) @(posedge ref_clk);
        meas(0, 60, hi, ri);
        chk("center rises", 16'd10, ri[15:0]);
        chk("center high", 16'd50, hi[15:0]);
        wr(8'h42, 8'h00);
        wr(8'h54, 8'h00);
        $display("test polarity done");
        // Clock A, clock B and scaled clocks, tick rate seen as edge count
        wr(8'h44, 8'h01);
        wr(8'h46, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(8'h42, 8'h00);
            wr(8'h48 + pin_t[i][7:0], 8'h00);
            wr(8'h40, clk_t[i]);
            wr(8'h41, pol_t[i]);
            wr(8'h42, 8'h01 << pin_t[i]);
            repeat (140) @(posedge ref_clk);
            meas(pin_t[i], 128, hi, ri);
            chk($sformatf("rises %0d", i), rise_t[i][15:0], ri[15:0]);
        end
        $display("test clock choice done");
        // Lower pair joined: period 0x0007, duty 0x0002
        wr(8'h42, 8'h00);
        wr(8'h40, 8'h40);
        wr(8'h41, 8'h00);
        wr(8'h4C, 8'h00);
        wr(8'h4D, 8'h07);
        wr(8'h50, 8'h00);
        wr(8'h51, 8'h02);
        wr(8'h48, 8'h00);
        wr(8'h49, 8'h00);
        wr(8'h42, 8'h01);
        repeat (20) @(posedge ref_clk);
        meas(0, 64, hi, ri);
        chk("joined high", 16'd48, hi[15:0]);
        chk("joined rises", 16'd8, ri[15:0]);
        chk("oe_n", 16'h000E, {12'h0, pin_oe_n});
        $display("test joined pair done");
        // Slow clock A: period write waits in buffer, counter write clears
        wr(8'h42, 8'h00);
        wr(8'h40, 8'h38);
        wr(8'h4C, 8'h05);
        wr(8'h48, 8'h00);
        wr(8'h42, 8'h01);
        repeat (300) @(posedge ref_clk);
        wr(8'h4C, 8'h02);
        rd(8'h4C, 8'h02);
        bus(1'b0, 8'h48, 8'h00, v);
        chk("counter ran", 16'h0001, {15'h0, v != 8'h00});
        wr(8'h42, 8'h00);
        wr(8'h48, 8'h00);
        rd(8'h48, 8'h00);
        bus(1'b0, 8'h43, 8'h00, v);
        repeat (5) @(posedge ref_clk);
        bus(1'b0, 8'h43, 8'h00, w);
        chk("prescaler held", {8'h00, v}, {8'h00, w});
        $display("test counter and prescaler done");
        final_report();
    end

    // Cut a hang short
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        $display("[ERR] run time expected end seen hang");
        final_report();
    end
endmodule // pcs_pwm_front_tb

`default_nettype wire
